//--- core/tah_pins.sv
// Host-facing pin logic of the touch converter: serial port, flags, GPIO
// Overview of operation
// (RULE1) Low select enables the shift register and starts a conversion.
// (RULE2) Serial input bits are taken on rising shift clock edges.
// (RULE3) Result bits leave on serial output, changing on falling edges.
// (RULE4) Serial output is high impedance whenever select is high.
// (RULE5) The host supplies the shift clock; the device has none.
// (RULE6) Result-ready goes low when new data reaches the results registers.
// (RULE7) Alert goes low on a set GPIO bit or an out-of-limit measurement.
// (RULE8) Pen touch is an active-low output with a pull-up.
// (RULE9) With hold monitoring on, acquisition stops while hold is active.
// (RULE10) Inputs numbered X+ 0, Y+ 1, Y- 2, aux 3-5, batteries 6-7.
// (RULE11) Each auxiliary analog pin can be reconfigured as a logic pin.
// (RULE12) One dedicated logic pin works as input or output.
// (RULE13) Results live in eleven registers readable over the serial link.
// (RULE14) Each active-low indication stays asserted until its cause clears.
`timescale 1ns/1ps
`default_nettype none
module tah_pins
	import tah_pkg::*;
(
	input  wire logic                clock,
	input  wire logic                rst,
	input  wire logic                serial_shift_clock,
	input  wire logic                chip_select_n,
	input  wire logic                serial_in,
	output logic                     serial_out,
	output logic                     serial_out_oe,
	output logic                     pen_touch_irq_n,
	output logic                     result_ready_n,
	output logic                     alert_n,
	input  wire logic                acquisition_hold,
	input  wire logic [2:0]          aux_input_pin_i,
	output logic      [2:0]          aux_input_pin_o,
	output logic      [2:0]          aux_input_pin_oe,
	input  wire logic                dedicated_logic_pin_i,
	output logic                     dedicated_logic_pin_o,
	output logic                     dedicated_logic_pin_oe,
	input  wire logic                result_valid,
	output logic                     result_ready,
	input  wire logic [IDX_W-1:0]    result_index,
	input  wire logic [DATA_W-1:0]   result_data,
	input  wire logic                pen_down,
	input  wire logic [3:0]          limit_exceeded,
	output logic                     conversion_start,
	output logic                     acquire_enable
);

	// Aux channels lose their conversions while used as logic pins
	function automatic logic is_aux_channel(input logic [IDX_W-1:0] ch);
		return (ch == CH_AUX1) || (ch == CH_AUX2) || (ch == CH_AUX3);
	endfunction : is_aux_channel

	// Address field extraction used by command decode
	function automatic logic [3:0] frame_addr(input logic [15:0] w);
		return w[ADDR_HI:ADDR_LO];
	endfunction : frame_addr

	// ---- Link domain (serial_shift_clock) ----
	logic [CNT_W-1:0]      rx_cnt_q;
	logic [FRAME_BITS-2:0] rx_shift_q;
	logic [FRAME_BITS-1:0] rx_word_q;
	logic                  rx_tgl_q;
	logic [CNT_W-1:0]      tx_cnt_q;
	wire                   rx_last;

	// ---- Core domain ----
	logic                  cs_s1_q;
	logic                  cs_s2_q;
	logic                  cs_s3_q;
	logic                  tgl_s1_q;
	logic                  tgl_s2_q;
	logic                  tgl_s3_q;
	logic                  hold_s1_q;
	logic                  hold_s2_q;
	logic [2:0]            aux_s1_q;
	logic [2:0]            aux_s2_q;
	logic                  ded_s1_q;
	logic                  ded_s2_q;
	logic [FRAME_BITS-1:0] tx_word_q;
	logic [3:0]            rd_addr_q;
	logic [DATA_W-1:0]     results_q [0:RESULT_REGS-1];
	logic [8:0]            cfg_q;
	logic [3:0]            gpio_out_q;
	logic [3:0]            limit_q;
	logic                  ready_n_q;
	logic                  alert_n_q;
	logic                  pen_n_q;
	logic                  conv_start_q;
	logic                  acq_en_q;

	wire                   selected;
	wire                   cs_fall;
	wire                   cmd_new;
	wire                   cmd_wr;
	wire [3:0]             cmd_addr;
	wire [10:0]            cmd_data;
	wire                   cmd_rd_result;
	wire                   wr_cfg;
	wire                   wr_gpio;
	wire                   wr_alert;
	wire [3:0]             gpio_en;
	wire [3:0]             gpio_dir;
	wire [3:0]             gpio_in;
	wire [3:0]             gpio_data;
	wire                   drain_take;
	wire                   drain_keep;
	wire [IDX_W-1:0]       drain_idx;
	wire [DATA_W-1:0]      drain_val;
	wire [DATA_W-1:0]      read_val;
	wire [3:0]             limit_clear;
	wire [1:0]             drain_aux_sel;

	tah_stream_if #(.WIDTH(STREAM_W)) fill_if ();
	tah_stream_if #(.WIDTH(STREAM_W)) drain_if ();

	// The result stream is buffered so the converter is not stalled by reads
	tah_fifo #(
		.WIDTH (STREAM_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock (clock),
		.rst   (rst),
		.wr    (fill_if.sink),
		.rd    (drain_if.source)
	);

	assign fill_if.valid = result_valid;
	assign fill_if.data  = {result_index, result_data};
	assign result_ready  = fill_if.ready;

	// (RULE5) host clock only
	// Shift clock stops between frames, so select high clears the counters
	assign rx_last = (rx_cnt_q == CNT_W'(FRAME_BITS - 1));

	// (RULE2) capture on rising edge
	always_ff @(posedge serial_shift_clock or posedge chip_select_n) begin
		if (chip_select_n) begin
			rx_cnt_q   <= '0;
			rx_shift_q <= '0;
		end else begin
			rx_cnt_q   <= rx_cnt_q + 1'b1;
			rx_shift_q <= {rx_shift_q[FRAME_BITS-3:0], serial_in};
		end
	end

	// Completed word is held until the next full frame; the toggle marks it
	// Core reset clears it at once; the shift clock is idle by then
	always_ff @(posedge serial_shift_clock or posedge rst) begin
		if (rst) begin
			rx_word_q <= '0;
			rx_tgl_q  <= 1'b0;
		end else if (rx_last) begin
			rx_word_q <= {rx_shift_q, serial_in};
			rx_tgl_q  <= ~rx_tgl_q;
		end
	end

	// (RULE3) advance on falling edge
	always_ff @(negedge serial_shift_clock or posedge chip_select_n) begin
		if (chip_select_n) begin
			tx_cnt_q <= '0;
		end else begin
			tx_cnt_q <= tx_cnt_q + 1'b1;
		end
	end

	// Word is static once the core sees the frame: it loads only while cs_s2_q is high
	assign serial_out = tx_word_q[CNT_W'(FRAME_BITS - 1) - tx_cnt_q];
	// (RULE4) released while deselected
	assign serial_out_oe = !chip_select_n;

	// Two-stage synchronisers for select, hold, the logic pins and the frame toggle
	always_ff @(posedge clock) begin
		if (rst) begin
			cs_s1_q   <= 1'b1;
			cs_s2_q   <= 1'b1;
			cs_s3_q   <= 1'b1;
			tgl_s1_q  <= 1'b0;
			tgl_s2_q  <= 1'b0;
			tgl_s3_q  <= 1'b0;
			hold_s1_q <= 1'b0;
			hold_s2_q <= 1'b0;
			aux_s1_q  <= '0;
			aux_s2_q  <= '0;
			ded_s1_q  <= 1'b0;
			ded_s2_q  <= 1'b0;
		end else begin
			cs_s1_q   <= chip_select_n;
			cs_s2_q   <= cs_s1_q;
			cs_s3_q   <= cs_s2_q;
			tgl_s1_q  <= rx_tgl_q;
			tgl_s2_q  <= tgl_s1_q;
			tgl_s3_q  <= tgl_s2_q;
			hold_s1_q <= acquisition_hold;
			hold_s2_q <= hold_s1_q;
			aux_s1_q  <= aux_input_pin_i;
			aux_s2_q  <= aux_s1_q;
			ded_s1_q  <= dedicated_logic_pin_i;
			ded_s2_q  <= ded_s1_q;
		end
	end

	// Frame and command decode
	assign selected      = !cs_s2_q;
	assign cs_fall       = cs_s3_q && !cs_s2_q;
	assign cmd_new       = tgl_s2_q ^ tgl_s3_q;
	assign cmd_wr        = rx_word_q[WR_BIT];
	assign cmd_addr      = frame_addr(rx_word_q);
	assign cmd_data      = rx_word_q[ADDR_LO-1:0];
	assign cmd_rd_result = cmd_new && !cmd_wr &&
	                       (cmd_addr < 4'(RESULT_REGS));
	assign wr_cfg        = cmd_new && cmd_wr && (cmd_addr == ADDR_CONFIG);
	assign wr_gpio       = cmd_new && cmd_wr && (cmd_addr == ADDR_GPIO);
	assign wr_alert      = cmd_new && cmd_wr && (cmd_addr == ADDR_ALERT);
	assign limit_clear   = wr_alert ? cmd_data[3:0] : 4'h0;

	// (RULE11) aux pins as logic pins
	// (RULE12) dedicated pin direction
	assign gpio_en   = {1'b1, cfg_q[CFG_EN_LO +: 3]};
	assign gpio_dir  = cfg_q[CFG_DIR_LO +: 4];
	assign gpio_in   = {ded_s2_q, aux_s2_q};
	assign gpio_data = gpio_en & ((gpio_dir & gpio_out_q) |
	                              (~gpio_dir & gpio_in));
	assign aux_input_pin_o        = gpio_out_q[2:0];
	assign aux_input_pin_oe       = gpio_en[2:0] & gpio_dir[2:0];
	assign dedicated_logic_pin_o  = gpio_out_q[3];
	assign dedicated_logic_pin_oe = gpio_dir[3];

	// Results are not updated mid-frame so a read sees one snapshot
	assign drain_if.ready = !selected;
	assign drain_take     = drain_if.valid && drain_if.ready;
	assign drain_idx      = drain_if.data[STREAM_W-1:DATA_W];
	assign drain_val      = drain_if.data[DATA_W-1:0];
	// Aux pin position; only used when the index is an aux channel
	assign drain_aux_sel = 2'(drain_idx - CH_AUX1);
	// (RULE10) aux numbering steers drop
	assign drain_keep = drain_take && (drain_idx < IDX_W'(RESULT_REGS)) &&
	                    !(is_aux_channel(drain_idx) &&
	                      gpio_en[drain_aux_sel]);

	// Readback value for the selected address
	assign read_val =
		(rd_addr_q < 4'(RESULT_REGS)) ? results_q[rd_addr_q] :
		(rd_addr_q == ADDR_CONFIG)    ? {3'h0, cfg_q} :
		(rd_addr_q == ADDR_GPIO)      ? {8'h00, gpio_data} :
		(rd_addr_q == ADDR_ALERT)     ? {8'h00, limit_q} : 12'h000;

	// (RULE13) eleven results registers
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < RESULT_REGS; i++) results_q[i] <= '0;
		end else if (drain_keep) begin
			results_q[drain_idx] <= drain_val;
		end
	end

	// Command side effects; read address is kept for the next frame
	always_ff @(posedge clock) begin
		if (rst) begin
			rd_addr_q  <= 4'h0;
			cfg_q      <= CFG_RESET;
			gpio_out_q <= GPIO_RESET;
		end else begin
			if (cmd_new && !cmd_wr) rd_addr_q <= cmd_addr;
			if (wr_cfg)  cfg_q      <= cmd_data[8:0];
			if (wr_gpio) gpio_out_q <= cmd_data[3:0];
		end
	end

	// Output word reloads only while the synchronised select is high
	// Select is seen two cycles late, so a reload may follow the fall;
	// the data bits leave several shift clocks later, once it has settled
	always_ff @(posedge clock) begin
		if (rst) begin
			tx_word_q <= '0;
		end else if (!selected) begin
			tx_word_q <= {rd_addr_q, read_val};
		end
	end

	// (RULE6) new data pulls low
	// (RULE14) held until read; set wins
	always_ff @(posedge clock) begin
		if (rst) begin
			ready_n_q <= 1'b1;
		end else if (drain_keep) begin
			ready_n_q <= 1'b0;
		end else if (cmd_rd_result) begin
			ready_n_q <= 1'b1;
		end
	end

	// (RULE7) sticky limit flags, set wins
	always_ff @(posedge clock) begin
		if (rst) begin
			limit_q <= 4'h0;
		end else begin
			limit_q <= limit_exceeded | (limit_q & ~limit_clear);
		end
	end

	// (RULE7) alert from GPIO or limits
	// (RULE14) released once causes clear
	always_ff @(posedge clock) begin
		if (rst) begin
			alert_n_q <= 1'b1;
		end else begin
			alert_n_q <= !((|gpio_data) || (|limit_q));
		end
	end

	// (RULE8) pen touch, low active
	// Pull-up is modelled as driving high when no touch
	always_ff @(posedge clock) begin
		if (rst) begin
			pen_n_q <= 1'b1;
		end else begin
			pen_n_q <= !pen_down;
		end
	end

	// (RULE1) select starts conversion
	// (RULE9) hold stops acquisition
	always_ff @(posedge clock) begin
		if (rst) begin
			conv_start_q <= 1'b0;
			acq_en_q     <= 1'b1;
		end else begin
			conv_start_q <= cs_fall;
			acq_en_q     <= !(cfg_q[CFG_HOLD] && hold_s2_q);
		end
	end

	assign result_ready_n   = ready_n_q;
	assign alert_n          = alert_n_q;
	assign pen_touch_irq_n  = pen_n_q;
	assign conversion_start = conv_start_q;
	assign acquire_enable   = acq_en_q;

endmodule : tah_pins
`default_nettype wire

//--- core/tah_pkg.sv
// Shared constants for the touch converter pin logic
package tah_pkg;

	// Serial frame layout
	localparam int unsigned FRAME_BITS = 16;
	localparam int unsigned CNT_W      = 4;
	localparam int unsigned WR_BIT     = 15;
	localparam int unsigned ADDR_HI    = 14;
	localparam int unsigned ADDR_LO    = 11;
	localparam int unsigned DATA_W     = 12;

	// Results storage and result stream
	localparam int unsigned RESULT_REGS = 11;
	localparam int unsigned IDX_W       = 4;
	localparam int unsigned STREAM_W    = IDX_W + DATA_W;
	localparam int unsigned FIFO_DEPTH  = 8;

	// Converter input numbering
	localparam logic [3:0] CH_X_PLUS  = 4'h0;
	localparam logic [3:0] CH_Y_PLUS  = 4'h1;
	localparam logic [3:0] CH_Y_MINUS = 4'h2;
	localparam logic [3:0] CH_AUX1    = 4'h3;
	localparam logic [3:0] CH_AUX2    = 4'h4;
	localparam logic [3:0] CH_AUX3    = 4'h5;
	localparam logic [3:0] CH_BAT_A   = 4'h6;
	localparam logic [3:0] CH_BAT_B   = 4'h7;

	// Command addresses beyond the results registers
	localparam logic [3:0] ADDR_CONFIG = 4'hc;
	localparam logic [3:0] ADDR_GPIO   = 4'hd;
	localparam logic [3:0] ADDR_ALERT  = 4'he;

	// Config word fields
	localparam int unsigned CFG_EN_LO   = 0;
	localparam int unsigned CFG_DIR_LO  = 4;
	localparam int unsigned CFG_HOLD    = 8;
	localparam logic [8:0]  CFG_RESET   = 9'h000;
	localparam logic [3:0]  GPIO_RESET  = 4'h0;

	// Limit flag positions
	localparam int unsigned LIM_AUX1   = 0;
	localparam int unsigned LIM_THERMAL_SENSE_1  = 1;
	localparam int unsigned LIM_BAT_A  = 2;
	localparam int unsigned LIM_BAT_B  = 3;

endpackage : tah_pkg

//--- core/tah_stream_if.sv
// Valid/ready stream carrier between the pin logic and its FIFO
`timescale 1ns/1ps
`default_nettype none
interface tah_stream_if #(
	parameter int unsigned WIDTH = 16
);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface : tah_stream_if
`default_nettype wire

//--- core/tah_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tah_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic  clock,
	input  wire logic  rst,
	tah_stream_if.sink   wr,
	tah_stream_if.source rd
);
	localparam int unsigned PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [0:DEPTH-1];
	logic [PW-1:0]    wr_ptr_q;
	logic [PW-1:0]    rd_ptr_q;
	logic [PW:0]      fill_q;
	wire              push;
	wire              pop;
	wire              full;
	wire              empty;

	// Honest flags from the fill count
	assign full     = (fill_q == (PW+1)'(DEPTH));
	assign empty    = (fill_q == '0);
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data  = mem_q[rd_ptr_q];
	assign push     = wr.valid && !full;
	assign pop      = rd.ready && !empty;

	// Storage needs no reset; only pointers and the fill count do
	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_ptr_q] <= wr.data;
		end
	end

	// Pointers wrap at a power-of-two depth
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			fill_q   <= '0;
		end else begin
			if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
			if (pop)  rd_ptr_q <= rd_ptr_q + 1'b1;
			fill_q <= fill_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule : tah_fifo
`default_nettype wire

//--- test/tah_pins_asserts.sv
// Concurrent checks on the touch converter pin logic ports
`timescale 1ns/1ps
`default_nettype none
module tah_pins_asserts
	import tah_pkg::*;
(
	input wire logic		clock,
	input wire logic		rst,
	input wire logic		chip_select_n,
	input wire logic		serial_out_oe,
	input wire logic		result_valid,
	input wire logic		result_ready,
	input wire logic [IDX_W-1:0]	result_index,
	input wire logic		result_ready_n,
	input wire logic		alert_n,
	input wire logic [3:0]		limit_exceeded,
	input wire logic		pen_down,
	input wire logic		pen_touch_irq_n,
	input wire logic		acquisition_hold,
	input wire logic		acquire_enable,
	input wire logic		conversion_start
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// Select and conversion start; pulse lags select by the synchroniser
	a_oe_follows_cs: assert property (
		serial_out_oe == !chip_select_n)
		else $error("serial output enable not tied to select");
	a_cs_starts_conv: assert property (
		$fell(chip_select_n) |-> ##[1:5] conversion_start)
		else $error("select fall gave no conversion start");
	a_conv_one_pulse: assert property (
		conversion_start |=> !conversion_start)
		else $error("conversion start longer than one cycle");
	a_conv_needs_cs: assert property (
		conversion_start |-> !$past(chip_select_n))
		else $error("conversion start without select low");

	// Indications; aux indices left out since a logic pin drops them
	a_ready_flag_set: assert property (
		(result_valid && result_ready && chip_select_n &&
		(result_index < 4'h3 ||
		(result_index > 4'h5 && result_index < 4'hb)))
		##1 chip_select_n [*6] |-> ##[0:2] !result_ready_n)
		else $error("stored result left ready flag high");
	a_pen_low: assert property (
		pen_down [*2] |=> !pen_touch_irq_n)
		else $error("pen touch not signalled");
	a_pen_release: assert property (
		!pen_down [*2] |=> pen_touch_irq_n)
		else $error("pen touch held after release");
	a_limit_alert: assert property (
		|limit_exceeded |-> ##[1:3] !alert_n)
		else $error("limit breach gave no alert");
	a_hold_free: assert property (
		!acquisition_hold [*4] |-> acquire_enable)
		else $error("acquisition stopped without hold");
endmodule : tah_pins_asserts

bind tah_pins tah_pins_asserts u_asserts (
	.clock(clock), .rst(rst), .chip_select_n(chip_select_n),
	.serial_out_oe(serial_out_oe), .result_valid(result_valid),
	.result_ready(result_ready), .result_index(result_index),
	.result_ready_n(result_ready_n), .alert_n(alert_n),
	.limit_exceeded(limit_exceeded), .pen_down(pen_down),
	.pen_touch_irq_n(pen_touch_irq_n),
	.acquisition_hold(acquisition_hold),
	.acquire_enable(acquire_enable),
	.conversion_start(conversion_start)
);
`default_nettype wire

//--- test/tah_host_model.sv
// Host processor model: serial bus master with its own shift clock
`timescale 1ns/1ps
`default_nettype none
module tah_host_model (
	output logic		serial_shift_clock,
	output logic		chip_select_n,
	output logic		serial_in,
	input  wire logic	serial_out,
	input  wire logic	serial_out_oe
);
	logic	last_bit;

	// Idle bus: clock parked low, select high
	// Select rises after time zero so the bit counters see their clear
	initial begin
		serial_shift_clock = 1'b0;
		chip_select_n = 1'b0;
		serial_in = 1'b0;
		last_bit = 1'b0;
		#1;
		chip_select_n = 1'b1;
	end

	// select without clock edges, a frame the device discards
	task automatic select(input logic lvl);
		chip_select_n = lvl;
		if (lvl) begin
			#200;
		end
	endtask : select

	// host makes the 48 ns clock only inside a frame
	// data set on the fall, reply taken before the rise
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		chip_select_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			serial_in = w[i];
			#24;
			r[i] = serial_out_oe ? serial_out : ~last_bit;
			last_bit = r[i];
			serial_shift_clock = 1'b1;
			#24;
			serial_shift_clock = 1'b0;
		end
		serial_in = ~w[0]; // Line driven to the inverse of the last bit
		#100;
		chip_select_n = 1'b1;
		#200; // Gap lets the reply word reload
	endtask : xfer
endmodule : tah_host_model
`default_nettype wire

//--- test/test_touch_adc_host_pins.sv
// Self-checking bench for the touch converter pin logic
`timescale 1ns/1ps
`default_nettype none
module test_touch_adc_host_pins;
	import tah_pkg::*;

	typedef struct {
		logic [3:0]	idx;
		logic [11:0]	dat;
	} tah_row_s;

	logic		clock, rst, acquisition_hold, result_valid;
	logic		pen_down, dedicated_ext;
	logic [2:0]	aux_ext;
	logic [3:0]	result_index, limit_exceeded;
	logic [11:0]	result_data;
	wire		serial_shift_clock, chip_select_n, serial_in;
	wire		serial_out, serial_out_oe, pen_touch_irq_n;
	wire		result_ready_n, alert_n, result_ready;
	wire		ded_i, ded_o, ded_oe, conversion_start, acquire_enable;
	wire [2:0]	aux_i, aux_o, aux_oe;
	int		err_count, checked;
	tah_row_s	rows [11];

	// Pin levels: a driven pin shows its driver, else the outside level
	assign aux_i = (aux_oe & aux_o) | (~aux_oe & aux_ext);
	assign ded_i = ded_oe ? ded_o : dedicated_ext;
	wire [7:0]	pin_vec = {aux_oe, ded_oe, aux_o, ded_o};
	wire [9:0]	rst_vec = {result_ready_n, alert_n, pen_touch_irq_n,
		conversion_start, acquire_enable, aux_oe, ded_oe, serial_out_oe};

	tah_pins dut (
		.clock(clock), .rst(rst), .serial_shift_clock(serial_shift_clock),
		.chip_select_n(chip_select_n), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe),
		.pen_touch_irq_n(pen_touch_irq_n), .result_ready_n(result_ready_n),
		.alert_n(alert_n), .acquisition_hold(acquisition_hold),
		.aux_input_pin_i(aux_i), .aux_input_pin_o(aux_o),
		.aux_input_pin_oe(aux_oe), .dedicated_logic_pin_i(ded_i),
		.dedicated_logic_pin_o(ded_o), .dedicated_logic_pin_oe(ded_oe),
		.result_valid(result_valid), .result_ready(result_ready),
		.result_index(result_index), .result_data(result_data),
		.pen_down(pen_down), .limit_exceeded(limit_exceeded),
		.conversion_start(conversion_start), .acquire_enable(acquire_enable)
	);

	tah_host_model host (
		.serial_shift_clock(serial_shift_clock),
		.chip_select_n(chip_select_n), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe)
	);

	// Core clock, 25 ns
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// Inputs set after a tick move 2 ns after the rising edge; the host model drives the serial pins on its own timing
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask : tick

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict

	// One result word; valid stays up so back-to-back words need no gap
	task automatic push(input logic [3:0] i, input logic [11:0] d);
		int n;
		n = 0;
		result_index = i;
		result_data = d;
		result_valid = 1'b1;
		while (result_ready !== 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
		if (n == 40) begin
			err_count++;
			give_verdict();
		end
		tick(1);
	endtask : push

	// Frames realign to the core clock afterwards
	task automatic rd(input logic [3:0] a, output logic [15:0] r);
		host.xfer({1'b0, a, 11'h000}, r);
		tick(1);
	endtask : rd

	task automatic wr(input logic [3:0] a, input logic [10:0] d);
		logic [15:0] r;
		host.xfer({1'b1, a, d}, r);
		tick(1);
	endtask : wr

	// Main sequence
	initial begin
		logic [15:0] r;
		err_count = 0;
		checked = 0;
		rst = 1'b0;
		acquisition_hold = 1'b0;
		result_valid = 1'b0;
		pen_down = 1'b0;
		dedicated_ext = 1'b0;
		aux_ext = 3'h5;
		result_index = 4'h0;
		result_data = 12'h000;
		limit_exceeded = 4'h0;
		// Reset rises after time zero so the link-side clear sees an edge
		#1;
		rst = 1'b1;
		tick(10);
		rst = 1'b0;
		tick(4);
		// Ordinary rows: each index stored, read back one frame later
		for (int i = 0; i < 11; i++) begin
			rows[i].idx = 4'(i);
			rows[i].dat = 12'h3c0 + 12'(i);
			push(rows[i].idx, rows[i].dat);
		end
		result_valid = 1'b0;
		tick(12);
		chk(16'(result_ready_n), 16'h0);
		rd(rows[0].idx, r);
		for (int i = 0; i < 11; i++) begin
			rd((i < 10) ? rows[i + 1].idx : ADDR_ALERT, r);
			chk(r, {rows[i].idx, rows[i].dat});
		end
		chk(16'(result_ready_n), 16'h1);
		// Logic pins driven out, then read as inputs
		wr(ADDR_CONFIG, 11'h0f7);
		wr(ADDR_GPIO, 11'h00a);
		chk(16'(pin_vec), 16'h00f5);
		chk(16'(alert_n), 16'h0);
		rd(ADDR_GPIO, r);
		host.xfer({1'b1, ADDR_CONFIG, 11'h007}, r);
		tick(1);
		chk(r, {ADDR_GPIO, 12'h00a});
		rd(ADDR_GPIO, r);
		rd(ADDR_GPIO, r);
		chk(r, {ADDR_GPIO, 12'h005});
		aux_ext = 3'h0;
		dedicated_ext = 1'b1;
		rd(ADDR_GPIO, r);
		rd(ADDR_GPIO, r);
		chk(r, {ADDR_GPIO, 12'h008});
		chk(16'(alert_n), 16'h0);
		// Dropped: aux index while its pin is logic, index past the last
		push(CH_AUX2, 12'h111);
		push(4'hb, 12'h222);
		result_valid = 1'b0;
		tick(12);
		chk(16'(result_ready_n), 16'h1);
		dedicated_ext = 1'b0;
		wr(ADDR_CONFIG, 11'h000);
		chk(16'(alert_n), 16'h1);
		// Hold is ignored until monitoring is switched on
		acquisition_hold = 1'b1;
		tick(6);
		chk(16'(acquire_enable), 16'h1);
		wr(ADDR_CONFIG, 11'h100);
		chk(16'(acquire_enable), 16'h0);
		acquisition_hold = 1'b0;
		tick(6);
		chk(16'(acquire_enable), 16'h1);
		// Each limit source: a one-cycle breach stays flagged until cleared
		for (int b = 0; b < 4; b++) begin
			limit_exceeded = 4'h1 << b;
			tick(1);
			limit_exceeded = 4'h0;
			tick(4);
			chk(16'(alert_n), 16'h0);
			wr(ADDR_ALERT, 11'h00f);
			chk(16'(alert_n), 16'h1);
		end
		pen_down = 1'b1;
		tick(3);
		chk(16'(pen_touch_irq_n), 16'h0);
		pen_down = 1'b0;
		tick(3);
		chk(16'(pen_touch_irq_n), 16'h1);
		// Select held low with no clock: FIFO fills, nothing is stored
		host.select(1'b0);
		tick(1);
		for (int k = 0; k < 8; k++) begin
			push(4'(k), 12'h0a0 + 12'(k));
		end
		result_valid = 1'b0;
		tick(1);
		chk(16'({result_ready, result_ready_n}), 16'h1);
		host.select(1'b1);
		tick(12);
		chk(16'({result_ready, result_ready_n}), 16'h2);
		rd(4'h7, r);
		rd(4'h0, r);
		chk(r, 16'h70a7);
		// Reset in mid-run with alert and pen asserted
		limit_exceeded = 4'h2;
		pen_down = 1'b1;
		tick(3);
		rst = 1'b1;
		limit_exceeded = 4'h0;
		pen_down = 1'b0;
		tick(3);
		rst = 1'b0;
		tick(1);
		chk(16'(rst_vec), 16'h03a0);
		give_verdict();
	end
endmodule : test_touch_adc_host_pins
`default_nettype wire
